// ### hw/mftdc_pkg.sv
package mftdc_pkg;

	// Register word indices on the AXI4-Lite bus; table offsets are not word aligned,
	// so each printed offset is an index and the byte address is four times it
	localparam logic [7:0] IDX_CAPLD0_HI  = 8'hF0;
	localparam logic [7:0] IDX_CAPLD0_LO  = 8'hF1;
	localparam logic [7:0] IDX_CAPLD1_HI  = 8'hF2;
	localparam logic [7:0] IDX_CAPLD1_LO  = 8'hF3;
	localparam logic [7:0] IDX_CMP0_HI    = 8'hF4;
	localparam logic [7:0] IDX_CMP0_LO    = 8'hF5;
	localparam logic [7:0] IDX_CMP1_HI    = 8'hF6;
	localparam logic [7:0] IDX_CMP1_LO    = 8'hF7;
	localparam logic [7:0] IDX_CTRL       = 8'hF8;
	localparam logic [7:0] IDX_DMA_CTRL   = 8'hE0;
	localparam logic [7:0] IDX_MASK       = 8'hE1;
	localparam logic [7:0] IDX_CNT_PTR    = 8'hE2;
	localparam logic [7:0] IDX_ADDR_PTR   = 8'hE3;
	localparam logic [7:0] IDX_GLOBAL     = 8'hE4;
	localparam logic [7:0] IDX_COUNTER_HI = 8'hE5;
	localparam logic [7:0] IDX_COUNTER_LO = 8'hE6;

	// Counter control fields
	localparam int B_RUN_EN    = 7;
	localparam int B_CLR_CAP   = 6;
	localparam int B_CLR_CMP   = 5;
	localparam int B_CLR_STB   = 4;
	localparam int B_DIR_SEL   = 3;
	localparam int B_DIR_STAT  = 2;
	localparam int B_OVF_CAP   = 1;
	localparam int B_RUNNING   = 0;
	// DMA control fields
	localparam int B_SWAP_EN   = 0;
	localparam int B_EOB_CMP   = 1;
	localparam int B_EOB_CAP   = 2;
	// Mask fields
	localparam int B_CAP_DMA_M = 0;
	localparam int B_CMP_DMA_M = 1;
	// Pointer toggle bit
	localparam int B_TOGGLE    = 2;

	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [15:0] RST_WORD   = 16'h0000;
	localparam logic [2:0]  PRIO_TOP   = 3'h0;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;

	// DMA handshake toward the controller
	typedef struct packed {
		logic       req;
		logic       second;
		logic [2:0] prio;
		logic       chan_cap;
		logic       eob_pulse;
	} mftdc_dma_t;

	// Timer events from the surrounding timer
	typedef struct packed {
		logic cap0;
		logic cap1;
		logic load0;
		logic load1;
		logic dir_fixed;
		logic dir_pin_up;
	} mftdc_evt_t;

endpackage

// ### hw/mftdc_top.sv
`timescale 1ns/10ps
module mftdc_top
	import mftdc_pkg::*;
#(
	parameter int          CNT_W    = 16,
	parameter logic [2:0]  BASE_PRIO = 3'h4,
	parameter logic [15:0] TABLE_LEN = 16'h0004
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write
	input  wire logic [11:0]       s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [11:0]       s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Timer events
	input  wire mftdc_evt_t        evt,
	// DMA request sources and controller acknowledge of one byte
	input  wire logic              cap0_dma_src,
	input  wire logic              cmp0_dma_src,
	input  wire logic              dma_byte_ack,
	output mftdc_dma_t             dma,
	// Interrupt requests toward the handler
	output logic                   eob_irq_cap,
	output logic                   eob_irq_cmp,
	output logic                   ovf_irq,
	output logic                   cmp0_match
);

	// Registers
	logic [15:0] capld0, capld1, cmp0, cmp1;
	logic [CNT_W-1:0] counter;
	logic        run_en, clr_cap, clr_cmp, dir_sel, ovf_cap0, global_en;
	logic        swap_en, eob_cmp, eob_cap, cap_mask, cmp_mask;
	logic [7:0]  cnt_ptr, addr_ptr;
	logic [15:0] txn_cap, txn_cmp;
	logic        busy, second, chan_cap, prescale_reload;
	logic        clr_strobe;

	// Bus handshake state
	logic        aw_held, w_held;
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;

	function automatic logic [7:0] word_idx(input logic [11:0] a);
		word_idx = a[9:2];
	endfunction

	function automatic logic hit(input logic [7:0] i);
		hit = (i == IDX_CAPLD0_HI) || (i == IDX_CAPLD0_LO) || (i == IDX_CAPLD1_HI) ||
			(i == IDX_CAPLD1_LO) || (i == IDX_CMP0_HI) || (i == IDX_CMP0_LO) ||
			(i == IDX_CMP1_HI) || (i == IDX_CMP1_LO) || (i == IDX_CTRL) ||
			(i == IDX_DMA_CTRL) || (i == IDX_MASK) || (i == IDX_CNT_PTR) ||
			(i == IDX_ADDR_PTR) || (i == IDX_GLOBAL) || (i == IDX_COUNTER_HI) ||
			(i == IDX_COUNTER_LO);
	endfunction

	// Write decode: only byte lane 0 carries the 8-bit registers
	wire       do_write = aw_held && w_held && !s_axi_bvalid;
	wire [7:0] widx     = word_idx(aw_addr);
	wire [7:0] wbyte    = w_data[7:0];
	wire       wen      = do_write && w_strb[0] && hit(widx);
	wire       wr_ctrl  = wen && (widx == IDX_CTRL);
	wire       wr_dctl  = wen && (widx == IDX_DMA_CTRL);

	// Counter behaviour
	wire       count_up  = evt.dir_fixed ? evt.dir_pin_up : dir_sel;
	wire       running   = run_en && global_en;
	wire       cmp0_hit  = (counter == cmp0[CNT_W-1:0]);
	wire       at_end    = count_up ? (&counter) : (counter == '0);
	wire       wrap      = running && at_end;
	wire       cap_evt   = evt.cap0 || evt.cap1;
	wire       clr_now   = clr_strobe || (clr_cap && cap_evt) ||
		(clr_cmp && cmp0_hit && running);

	// DMA request gating and completion
	wire       cap_req   = cap0_dma_src && cap_mask;
	wire       cmp_req   = cmp0_dma_src && cmp_mask;
	wire       word_done = busy && second && dma_byte_ack;
	wire [15:0] txn_next = (chan_cap ? txn_cap : txn_cmp) + 16'h0001;
	wire       block_end = word_done && (txn_next == TABLE_LEN);
	wire       end_cap   = block_end && chan_cap;
	wire       end_cmp   = block_end && !chan_cap;

	// Write handshake, addresses and data held until both are present
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= hit(widx) ? RESP_OKAY : RESP_SLV;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Readies come from flops fed by the next handshake state; low for one cycle after reset
	wire       next_aw_held = !do_write && (aw_held || (s_axi_awvalid && s_axi_awready));
	wire       next_w_held  = !do_write && (w_held || (s_axi_wvalid && s_axi_wready));
	wire       next_bvalid  = do_write || (s_axi_bvalid && !s_axi_bready);
	wire       next_rvalid  = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_awready <= !next_aw_held && !next_bvalid;
			s_axi_wready  <= !next_w_held && !next_bvalid;
			s_axi_arready <= !next_rvalid;
		end
	end

	// Read port, one cycle from address to data
	wire [7:0] ridx = word_idx(s_axi_araddr);
	logic [7:0] rbyte;
	always_comb begin
		rbyte = RST_BYTE;
		case (ridx)
			IDX_CAPLD0_HI:  rbyte = capld0[15:8];
			IDX_CAPLD0_LO:  rbyte = capld0[7:0];
			IDX_CAPLD1_HI:  rbyte = capld1[15:8];
			IDX_CAPLD1_LO:  rbyte = capld1[7:0];
			IDX_CMP0_HI:    rbyte = cmp0[15:8];
			IDX_CMP0_LO:    rbyte = cmp0[7:0];
			IDX_CMP1_HI:    rbyte = cmp1[15:8];
			IDX_CMP1_LO:    rbyte = cmp1[7:0];
			// Strobe bit always reads zero status bits
			IDX_CTRL:       rbyte = {run_en, clr_cap, clr_cmp, 1'b0,
				dir_sel, count_up, ovf_cap0, running};
			IDX_DMA_CTRL:   rbyte = {5'h00, eob_cap, eob_cmp, swap_en};
			IDX_MASK:       rbyte = {6'h00, cmp_mask, cap_mask};
			IDX_CNT_PTR:    rbyte = cnt_ptr;
			IDX_ADDR_PTR:   rbyte = addr_ptr;
			IDX_GLOBAL:     rbyte = {7'h00, global_en};
			IDX_COUNTER_HI: rbyte = counter[15:8];
			IDX_COUNTER_LO: rbyte = counter[7:0];
			default:        rbyte = RST_BYTE;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, rbyte};
			s_axi_rresp  <= hit(ridx) ? RESP_OKAY : RESP_SLV;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Counter control; strobe bit self clears one cycle after the write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_en <= 1'b0;
			clr_cap <= 1'b0;
			clr_cmp <= 1'b0;
			dir_sel <= 1'b0;
			clr_strobe <= 1'b0;
			global_en <= 1'b1;
		end else begin
			clr_strobe <= wr_ctrl && wbyte[B_CLR_STB];
			if (wr_ctrl) begin
				run_en  <= wbyte[B_RUN_EN];
				clr_cap <= wbyte[B_CLR_CAP];
				clr_cmp <= wbyte[B_CLR_CMP];
				dir_sel <= wbyte[B_DIR_SEL];
			end
			if (wen && widx == IDX_GLOBAL)
				global_en <= wbyte[0];
		end
	end

	// Counter: start without reload, clear has priority over counting
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			counter <= RST_WORD[CNT_W-1:0];
			prescale_reload <= 1'b0;
			ovf_irq <= 1'b0;
			cmp0_match <= 1'b0;
		end else begin
			prescale_reload <= clr_now && !clr_strobe;
			ovf_irq <= wrap && !clr_now; // Software clear raises no request
			cmp0_match <= cmp0_hit && running;
			if (clr_now)
				counter <= '0;
			else if (running)
				counter <= count_up ? counter + CNT_W'(1) : counter - CNT_W'(1);
		end
	end

	// Capture/load and compare registers; undefined reset kept as zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			capld0 <= RST_WORD;
			capld1 <= RST_WORD;
			cmp0 <= RST_WORD;
			cmp1 <= RST_WORD;
			ovf_cap0 <= 1'b0;
		end else begin
			// Triggers act regardless of the run enable
			if (evt.cap0) begin
				capld0 <= 16'(counter);
				ovf_cap0 <= wrap;
			end
			if (evt.cap1)
				capld1 <= 16'(counter);
			if (wen && widx == IDX_CAPLD0_HI) capld0[15:8] <= wbyte;
			if (wen && widx == IDX_CAPLD0_LO) capld0[7:0]  <= wbyte;
			if (wen && widx == IDX_CAPLD1_HI) capld1[15:8] <= wbyte;
			if (wen && widx == IDX_CAPLD1_LO) capld1[7:0]  <= wbyte;
			if (wen && widx == IDX_CMP0_HI)   cmp0[15:8]   <= wbyte;
			if (wen && widx == IDX_CMP0_LO)   cmp0[7:0]    <= wbyte;
			if (wen && widx == IDX_CMP1_HI)   cmp1[15:8]   <= wbyte;
			if (wen && widx == IDX_CMP1_LO)   cmp1[7:0]    <= wbyte;
		end
	end

	// Word sequencer: capture channel wins only when idle; a started word is never preempted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			second <= 1'b0;
			chan_cap <= 1'b0;
			txn_cap <= RST_WORD;
			txn_cmp <= RST_WORD;
		end else begin
			if (!busy && (cap_req || cmp_req)) begin
				busy <= 1'b1;
				chan_cap <= cap_req;
			end else if (busy && dma_byte_ack && !second) begin
				second <= 1'b1;
			end else if (word_done) begin
				busy <= 1'b0;
				second <= 1'b0;
				if (chan_cap)
					txn_cap <= block_end ? RST_WORD : txn_next;
				else
					txn_cmp <= block_end ? RST_WORD : txn_next;
			end
		end
	end

	// Request out: top priority only for the second byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dma <= '0;
		end else begin
			dma.req       <= busy && !word_done;
			dma.second    <= second && !word_done;
			dma.prio      <= second ? PRIO_TOP : BASE_PRIO;
			dma.chan_cap  <= chan_cap;
			dma.eob_pulse <= block_end;
		end
	end

	// End of block flags, masks and swap toggles; hardware set wins over software clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			swap_en <= 1'b0;
			eob_cap <= 1'b0;
			eob_cmp <= 1'b0;
			cap_mask <= 1'b0;
			cmp_mask <= 1'b0;
			cnt_ptr <= RST_BYTE;
			addr_ptr <= RST_BYTE;
			eob_irq_cap <= 1'b0;
			eob_irq_cmp <= 1'b0;
		end else begin
			if (wr_dctl) begin
				swap_en <= wbyte[B_SWAP_EN];
				eob_cmp <= wbyte[B_EOB_CMP];
				eob_cap <= wbyte[B_EOB_CAP];
			end
			if (end_cap) eob_cap <= 1'b1;
			if (end_cmp) eob_cmp <= 1'b1;
			if (wen && widx == IDX_MASK) begin
				cap_mask <= wbyte[B_CAP_DMA_M];
				cmp_mask <= wbyte[B_CMP_DMA_M];
			end
			// Overwrite guard: stale pointer pair would corrupt memory
			if (end_cap && eob_cap) cap_mask <= 1'b0;
			if (end_cmp && eob_cmp) cmp_mask <= 1'b0;
			if (wen && widx == IDX_CNT_PTR)  cnt_ptr  <= wbyte;
			if (wen && widx == IDX_ADDR_PTR) addr_ptr <= wbyte;
			if (swap_en && end_cmp) cnt_ptr[B_TOGGLE]  <= !cnt_ptr[B_TOGGLE];
			if (swap_en && end_cap) addr_ptr[B_TOGGLE] <= !addr_ptr[B_TOGGLE];
			// One-cycle requests; handler ranks them below DMA and overflow
			eob_irq_cap <= end_cap ||
				(wr_dctl && swap_en && wbyte[B_EOB_CAP] && !eob_cap);
			eob_irq_cmp <= end_cmp ||
				(wr_dctl && swap_en && wbyte[B_EOB_CMP] && !eob_cmp);
		end
	end

endmodule

// ### tb/mftdc_checker.sv
`timescale 1ns/10ps
module mftdc_checker
	import mftdc_pkg::*;
#(
	parameter logic [2:0] BASE_PRIO = 3'h4
) (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Register read
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	// DMA and interrupts
	input wire mftdc_dma_t  dma,
	input wire logic        dma_byte_ack,
	input wire logic        cap0_dma_src,
	input wire logic        cmp0_dma_src,
	input wire logic        eob_irq_cap,
	input wire logic        eob_irq_cmp
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Marks a control register read in flight
	logic rd_ctrl;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			rd_ctrl <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			rd_ctrl <= (s_axi_araddr == {2'b00, IDX_CTRL, 2'b00});
	end
	// Byte steps of one word
	sequence first_byte_s;
		dma.req && !dma.second && dma_byte_ack;
	endsequence
	sequence last_byte_s;
		dma.req && dma.second && dma_byte_ack;
	endsequence
	word_next_a: assert property (first_byte_s |-> ##2 dma.req && dma.second)
		else $error("second byte missing");
	word_end_a: assert property (last_byte_s |=> !dma.req)
		else $error("word not ended");
	prio_top_a: assert property (dma.second |-> dma.prio == PRIO_TOP)
		else $error("second byte priority");
	prio_back_a: assert property (dma.req && !dma.second |-> dma.prio == BASE_PRIO)
		else $error("first byte priority");
	chan_keep_a: assert property (dma.req && $past(dma.req) |-> $stable(dma.chan_cap))
		else $error("channel changed in word");
	req_cause_a: assert property ($rose(dma.req) |-> $past(cap0_dma_src || cmp0_dma_src, 2))
		else $error("request without source");
	eob_irq_a: assert property (dma.eob_pulse |-> eob_irq_cap || eob_irq_cmp)
		else $error("block end without irq");
	clr_zero_a: assert property (s_axi_rvalid && rd_ctrl |-> !s_axi_rdata[B_CLR_STB])
		else $error("clear strobe read one");
endmodule

// ### tb/mftdc_dma_partner.sv
`timescale 1ns/10ps
module mftdc_dma_partner
	import mftdc_pkg::*;
(
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Request side and answer delay
	input wire mftdc_dma_t dma,
	input wire logic [3:0] pw,
	output logic           dma_byte_ack
);
	logic [3:0] cnt;
	logic       acked;
	logic       last_sec;
	// One byte per phase; never acks the same byte twice
	wire ready_now = dma.req && !dma_byte_ack && (!acked || dma.second != last_sec);
	always_ff @(posedge aclk) begin
		if (!aresetn || !dma.req) begin
			cnt <= 4'h0;
			acked <= 1'b0;
			last_sec <= 1'b0;
			dma_byte_ack <= 1'b0;
		end else if (ready_now && cnt >= pw) begin
			dma_byte_ack <= 1'b1;
			acked <= 1'b1;
			last_sec <= dma.second;
			cnt <= 4'h0;
		end else begin
			dma_byte_ack <= 1'b0;
			cnt <= ready_now ? cnt + 4'h1 : cnt;
		end
	end
endmodule

// ### tb/mftdc_top_tb.sv
`timescale 1ns/10ps
module mftdc_top_tb;
	import mftdc_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, cap0_dma_src, cmp0_dma_src, dma_byte_ack;
	logic        eob_irq_cap, eob_irq_cmp, ovf_irq, cmp0_match;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, pw;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [7:0]  h, l;
	mftdc_evt_t  evt;
	mftdc_dma_t  dma;
	int          mismatches, check_count, tick, acks, ack_at, eob_n, ovf_n, cmp_cyc;
	int          cmp_n, eoc_n;
	typedef struct {
		logic [7:0] ix;
		logic [7:0] wd;
		logic [7:0] ex;
		logic [1:0] rs;
	} mftdc_row_t;
	// Write value, expected readback, expected response
	mftdc_row_t rows [7] = '{
		'{IDX_CMP0_HI, 8'hA5, 8'hA5, RESP_OKAY}, '{IDX_CMP1_LO, 8'h5A, 8'h5A, RESP_OKAY},
		'{IDX_CAPLD1_HI, 8'h3C, 8'h3C, RESP_OKAY}, '{IDX_CNT_PTR, 8'h04, 8'h04, RESP_OKAY},
		'{IDX_ADDR_PTR, 8'hFB, 8'hFB, RESP_OKAY}, '{IDX_CTRL, 8'h18, 8'h0C, RESP_OKAY},
		'{8'h10, 8'h77, 8'h00, RESP_SLV}};

	mftdc_top #(.TABLE_LEN(16'h0002)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .evt, .cap0_dma_src,
		.cmp0_dma_src, .dma_byte_ack, .dma, .eob_irq_cap, .eob_irq_cmp, .ovf_irq, .cmp0_match);
	mftdc_dma_partner u_dmac (.aclk, .aresetn, .dma, .pw, .dma_byte_ack);

	task automatic conclude();
		if (mismatches == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Handshakes sampled mid-cycle, released after the taking edge
	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		logic a, w, b;
		a = 1'b1;
		w = 1'b1;
		b = 1'b0;
		s_axi_awaddr <= {2'b00, ix, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b) begin
			@(negedge aclk);
			b = s_axi_bvalid;
			r = s_axi_bresp;
			a = a && !s_axi_awready;
			w = w && !s_axi_wready;
			@(posedge aclk);
			s_axi_awvalid <= a;
			s_axi_wvalid <= w;
		end
		s_axi_bready <= 1'b0;
		// One edge between calls, so no signal is driven twice in one step
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] ix, output logic [7:0] d);
		logic a, v;
		a = 1'b1;
		v = 1'b0;
		s_axi_araddr <= {2'b00, ix, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!v) begin
			@(negedge aclk);
			v = s_axi_rvalid;
			d = s_axi_rdata[7:0];
			r = s_axi_rresp;
			a = a && !s_axi_arready;
			@(posedge aclk);
			s_axi_arvalid <= a;
		end
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rc(input logic [7:0] ix, input logic [7:0] exp);
		logic [7:0] d;
		rd(ix, d);
		chk(d, exp);
	endtask
	task automatic rst();
		aresetn <= 1'b0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	// Event counters and the hang limit
	always @(posedge aclk) begin
		tick <= tick + 1;
		acks <= acks + int'(dma_byte_ack);
		eob_n <= eob_n + int'(eob_irq_cap);
		ovf_n <= ovf_n + int'(ovf_irq);
		cmp_cyc <= cmp_cyc + int'(dma.req && !dma.chan_cap);
		cmp_n <= cmp_n + int'(cmp0_match);
		eoc_n <= eoc_n + int'(eob_irq_cmp);
		if (eob_irq_cap && eob_n == 0)
			ack_at <= acks;
		if (tick == 20000) begin
			mismatches++;
			conclude();
		end
	end

	initial begin
		{mismatches, check_count, tick, acks, ack_at, eob_n, ovf_n, cmp_cyc} = '0;
		{cmp_n, eoc_n} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
		{cap0_dma_src, cmp0_dma_src, evt} <= '0;
		s_axi_wstrb <= 4'h1;
		pw <= 4'h0;
		rst();
		foreach (rows[i]) begin
			wr(rows[i].ix, rows[i].wd);
			chk({6'h0, r}, {6'h0, rows[i].rs});
			rc(rows[i].ix, rows[i].ex);
		end
		// Reset again in mid-run
		rst();
		rc(IDX_CMP0_HI, RST_BYTE);
		rc(IDX_CTRL, RST_BYTE);
		rc(IDX_GLOBAL, 8'h01);
		wr(IDX_CTRL, 8'h88);
		rc(IDX_CTRL, 8'h8D);
		wr(IDX_GLOBAL, 8'h00);
		rc(IDX_CTRL, 8'h8C);
		wr(IDX_GLOBAL, 8'h01);
		// Let the count pass 0x100, then stop and clear it in one write
		repeat (300) @(posedge aclk);
		wr(IDX_CTRL, 8'h18);
		rc(IDX_COUNTER_HI, 8'h00);
		rc(IDX_COUNTER_LO, 8'h00);
		// Compare match at 0x80 keeps the high byte at zero, two matches in 300 cycles
		wr(IDX_CMP0_LO, 8'h80);
		wr(IDX_CTRL, 8'hA8);
		l = 8'(cmp_n);
		repeat (300) @(posedge aclk);
		chk(8'(cmp_n), l + 8'h02);
		rc(IDX_COUNTER_HI, 8'h00);
		// Stopped counter still captures
		wr(IDX_CTRL, 8'h08);
		rd(IDX_COUNTER_HI, h);
		rd(IDX_COUNTER_LO, l);
		evt.cap0 <= 1'b1;
		@(posedge aclk);
		evt.cap0 <= 1'b0;
		rc(IDX_CAPLD0_HI, h);
		rc(IDX_CAPLD0_LO, l);
		wr(IDX_CTRL, 8'hC8);
		repeat (60) @(posedge aclk);
		evt.cap1 <= 1'b1;
		@(posedge aclk);
		evt.cap1 <= 1'b0;
		rd(IDX_COUNTER_LO, l);
		chk({7'h0, l < 8'h0C}, 8'h01);
		wr(IDX_CTRL, 8'h48);
		chk(8'(ovf_n), 8'h00);
		evt.dir_fixed <= 1'b1;
		rc(IDX_CTRL, 8'h48);
		evt.dir_fixed <= 1'b0;
		// Swap mode, only the capture channel unmasked
		wr(IDX_ADDR_PTR, 8'h00);
		wr(IDX_DMA_CTRL, 8'h01);
		wr(IDX_MASK, 8'h01);
		cap0_dma_src <= 1'b1;
		cmp0_dma_src <= 1'b1;
		while (eob_n < 1) @(posedge aclk);
		pw <= 4'h2;
		chk(8'(ack_at), 8'h04);
		rc(IDX_ADDR_PTR, 8'h04);
		rc(IDX_DMA_CTRL, 8'h05);
		while (eob_n < 2) @(posedge aclk);
		rc(IDX_MASK, 8'h00);
		chk(8'(cmp_cyc), 8'h00);
		cap0_dma_src <= 1'b0;
		// Flag cleared before the mask is set again
		wr(IDX_DMA_CTRL, 8'h01);
		wr(IDX_MASK, 8'h01);
		h = 8'(eob_n);
		wr(IDX_DMA_CTRL, 8'h07);
		repeat (3) @(posedge aclk);
		chk(8'(eob_n), h + 8'h01);
		chk(8'(eoc_n), 8'h01);
		conclude();
	end
endmodule

bind mftdc_top mftdc_checker #(.BASE_PRIO(BASE_PRIO)) u_chk (.aclk, .aresetn, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .dma, .dma_byte_ack,
	.cap0_dma_src, .cmp0_dma_src, .eob_irq_cap, .eob_irq_cmp);
